// [ccm_defines.vh]
// Constants of the charger configuration and mask register bank.
// Included by ccm_regs.v; holds definitions only.
`ifndef CCM_DEFINES_VH
`define CCM_DEFINES_VH

// Register offsets
`define CCM_OFS_EVENT_MASK_TWO   8'h07
`define CCM_OFS_CFG_DELAY_MASK   8'h08
`define CCM_OFS_CFG_SERVO_PROT   8'h09
`define CCM_OFS_VOLTAGE_CODE_HI  8'h0a

// Reset values
`define CCM_RST_EVENT_MASK_TWO   8'h00
`define CCM_RST_CFG_DELAY_MASK   8'h28
`define CCM_RST_CFG_SERVO_PROT   8'hf3
`define CCM_RST_VOLTAGE_CODE_HI  8'h32
`define CCM_RST_VOLTAGE_CODE     11'h190

// Writable bits; all others ignore writes and read zero
`define CCM_WR_EVENT_MASK_TWO    8'h7f
`define CCM_WR_CFG_DELAY_MASK    8'hf8
`define CCM_WR_CFG_SERVO_PROT    8'hff
`define CCM_WR_VOLTAGE_CODE_HI   8'hff

// Field positions
`define CCM_PG_DLY_HI            7
`define CCM_PG_DLY_LO            6
`define CCM_GLOBAL_MASK_BIT      5
`define CCM_BIAS_DLY_HI          4
`define CCM_BIAS_DLY_LO          3
`define CCM_SERVO_CLK_HI         7
`define CCM_SERVO_CLK_LO         6
`define CCM_DISCH_SERVO_BIT      5
`define CCM_DISCH_OFF_BIT        4
`define CCM_UVP_DISABLE_BIT      3
`define CCM_LATCH_OFF_BIT        2
`define CCM_AUX5V_EN_BIT         1
`define CCM_AUX_LDO_EN_BIT       0

// Voltage code saturation point
`define CCM_VCODE_SAT            11'h780
// Output step, in 0.1 mV units (12.5 mV)
`define CCM_VOUT_STEP_TENTH_MV   18'd125

// Delay timing: one delay step is 250 us at a 20 MHz clock
`define CCM_CLK_MHZ              20
`define CCM_DLY_STEP_US          250
`define CCM_DLY_STEP_CYCLES      (`CCM_DLY_STEP_US * `CCM_CLK_MHZ)
// Delay lengths in 250 us steps: power-good 0/0.25/1/4 ms, bias-good 1/1.25/1.5/3 ms
`define CCM_PG_TICKS_0           5'd0
`define CCM_PG_TICKS_1           5'd1
`define CCM_PG_TICKS_2           5'd4
`define CCM_PG_TICKS_3           5'd16
`define CCM_BIAS_TICKS_0         5'd4
`define CCM_BIAS_TICKS_1         5'd5
`define CCM_BIAS_TICKS_2         5'd6
`define CCM_BIAS_TICKS_3         5'd12

// Base servo step period in clock cycles
`define CCM_SERVO_BASE_CYCLES    20

`endif

// [ccm_regs.v]
// Charger configuration and mask register bank with delay timers and servo step divider.
// Assumes a serial-bus front end outside that turns host transfers into byte
// register accesses on the internal port, all synchronous to clk.
//
// Behaviour
// - Mask-two bits 6..0 suppress matching flag-two events
// - Global mask forces all mask bits to one
// - Global mask clear: stored mask bits apply
// - Power-good delay: 0, 0.25, 1, 4 ms
// - Bias-good delay: 1, 1.25, 1.5, 3 ms
// - Servo step period base times 1,2,4,8
// - Discharge resistor used while servoing downward
// - Discharge resistor used while converter disabled
// - Bit three disables undervoltage protection
// - Bit two selects latch-off over hiccup
// - Bit one enables auxiliary 5 V converter
// - Bit zero enables auxiliary linear regulator
// - Code bits 10..3 here, reset 0x32
// - Each code step is 12.5 mV output
// - Combined voltage code resets to 0x190
// - Codes 0x780 and above saturate at 24 V
// - Effectively masked flag raises no event
// - New code applies only on load strobe
`timescale 1ns/10ps
`include "ccm_defines.vh"

module ccm_regs #(
    parameter DLY_STEP_CYCLES   = `CCM_DLY_STEP_CYCLES,
    parameter SERVO_BASE_CYCLES = `CCM_SERVO_BASE_CYCLES
) (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    // Internal register port
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // Event flags and first mask byte kept elsewhere
    input  wire [7:0]  event_flags_one,
    input  wire [7:0]  event_flags_two,
    input  wire [7:0]  event_mask_one,
    output reg  [7:0]  event_raise_one,
    output reg  [7:0]  event_raise_two,
    output reg         event_raise_any,
    // Voltage code
    input  wire [2:0]  voltage_code_low,
    input  wire        voltage_code_load,
    output reg  [10:0] voltage_code_active,
    output reg  [10:0] voltage_code_sat,
    output reg  [17:0] vout_tenth_mv,
    // Good indicators
    input  wire        power_good_cond,
    input  wire        bias_good_cond,
    output wire        power_good_pin,
    output wire        bias_good_pin,
    // Converter control
    input  wire        main_converter_on,
    input  wire        servo_down,
    output reg         servo_step,
    output reg         discharge_on,
    output wire        undervoltage_protect_disable,
    output wire        latch_off_select,
    output wire        aux_5v_enable,
    output wire        aux_regulator_enable
);

    reg  [7:0] event_mask_two_reg;
    reg  [7:0] cfg_delay_mask_reg;
    reg  [7:0] cfg_servo_prot_reg;
    reg  [7:0] voltage_code_high_reg;
    reg  [15:0] servo_cnt_reg;

    wire        global_mask = cfg_delay_mask_reg[`CCM_GLOBAL_MASK_BIT];
    wire [1:0]  pg_sel      = cfg_delay_mask_reg[`CCM_PG_DLY_HI:`CCM_PG_DLY_LO];
    wire [1:0]  bias_sel    = cfg_delay_mask_reg[`CCM_BIAS_DLY_HI:`CCM_BIAS_DLY_LO];
    wire [1:0]  servo_sel   = cfg_servo_prot_reg[`CCM_SERVO_CLK_HI:`CCM_SERVO_CLK_LO];
    wire [10:0] code_staged = {voltage_code_high_reg, voltage_code_low};
    wire [15:0] servo_base  = SERVO_BASE_CYCLES[15:0];
    wire [15:0] servo_period;
    wire [7:0]  eff_mask_one;
    wire [7:0]  eff_mask_two;
    wire [1:0]  good_cond;
    wire [1:0]  good_pin;

    // Writable-bit mask for an offset; zero means unmapped
    function [7:0] ccm_wr_mask;
        input [7:0] addr;
        begin
            case (addr)
                `CCM_OFS_EVENT_MASK_TWO:  ccm_wr_mask = `CCM_WR_EVENT_MASK_TWO;
                `CCM_OFS_CFG_DELAY_MASK:  ccm_wr_mask = `CCM_WR_CFG_DELAY_MASK;
                `CCM_OFS_CFG_SERVO_PROT:  ccm_wr_mask = `CCM_WR_CFG_SERVO_PROT;
                `CCM_OFS_VOLTAGE_CODE_HI: ccm_wr_mask = `CCM_WR_VOLTAGE_CODE_HI;
                default:                  ccm_wr_mask = 8'h00;
            endcase
        end
    endfunction

    // Delay length in 250 us steps for channel 0 (power-good) or 1 (bias-good)
    function [4:0] ccm_delay_ticks;
        input       chan;
        input [1:0] sel;
        begin
            case ({chan, sel})
                3'h0:    ccm_delay_ticks = `CCM_PG_TICKS_0;
                3'h1:    ccm_delay_ticks = `CCM_PG_TICKS_1;
                3'h2:    ccm_delay_ticks = `CCM_PG_TICKS_2;
                3'h3:    ccm_delay_ticks = `CCM_PG_TICKS_3;
                3'h4:    ccm_delay_ticks = `CCM_BIAS_TICKS_0;
                3'h5:    ccm_delay_ticks = `CCM_BIAS_TICKS_1;
                3'h6:    ccm_delay_ticks = `CCM_BIAS_TICKS_2;
                3'h7:    ccm_delay_ticks = `CCM_BIAS_TICKS_3;
                default: ccm_delay_ticks = 5'd0;
            endcase
        end
    endfunction

    // Register writes; only writable bits change, bit 7 of mask two stays zero
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            event_mask_two_reg    <= `CCM_RST_EVENT_MASK_TWO;
            cfg_delay_mask_reg    <= `CCM_RST_CFG_DELAY_MASK;
            cfg_servo_prot_reg    <= `CCM_RST_CFG_SERVO_PROT;
            voltage_code_high_reg <= `CCM_RST_VOLTAGE_CODE_HI;
        end else if (reg_wr) begin
            case (reg_addr)
                `CCM_OFS_EVENT_MASK_TWO:
                    event_mask_two_reg <= reg_wdata & ccm_wr_mask(reg_addr);
                `CCM_OFS_CFG_DELAY_MASK:
                    cfg_delay_mask_reg <= reg_wdata & ccm_wr_mask(reg_addr);
                `CCM_OFS_CFG_SERVO_PROT:
                    cfg_servo_prot_reg <= reg_wdata & ccm_wr_mask(reg_addr);
                `CCM_OFS_VOLTAGE_CODE_HI:
                    voltage_code_high_reg <= reg_wdata & ccm_wr_mask(reg_addr);
                default: ;
            endcase
        end
    end

    // Read data registered one cycle after the strobe; unmapped offsets read zero
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `CCM_OFS_EVENT_MASK_TWO:  reg_rdata <= event_mask_two_reg & ccm_wr_mask(reg_addr);
                    `CCM_OFS_CFG_DELAY_MASK:  reg_rdata <= cfg_delay_mask_reg & ccm_wr_mask(reg_addr);
                    `CCM_OFS_CFG_SERVO_PROT:  reg_rdata <= cfg_servo_prot_reg;
                    `CCM_OFS_VOLTAGE_CODE_HI: reg_rdata <= voltage_code_high_reg;
                    default:                  reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Effective masks: the global bit overrides stored contents
    assign eff_mask_one = global_mask ? 8'hff : event_mask_one;
    assign eff_mask_two = global_mask ? 8'hff : {1'b0, event_mask_two_reg[6:0]};

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            event_raise_one <= 8'h00;
            event_raise_two <= 8'h00;
            event_raise_any <= 1'b0;
        end else begin
            event_raise_one <= event_flags_one & ~eff_mask_one;
            event_raise_two <= event_flags_two & ~eff_mask_two;
            event_raise_any <= |{event_flags_one & ~eff_mask_one, event_flags_two & ~eff_mask_two};
        end
    end

    // Staged code becomes active only on the load strobe; a write alone changes nothing
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            voltage_code_active <= `CCM_RST_VOLTAGE_CODE;
            voltage_code_sat    <= `CCM_RST_VOLTAGE_CODE;
            vout_tenth_mv       <= 18'd0;
        end else begin
            if (voltage_code_load) begin
                voltage_code_active <= code_staged;
            end
            if (voltage_code_active >= `CCM_VCODE_SAT) begin
                voltage_code_sat <= `CCM_VCODE_SAT;
            end else begin
                voltage_code_sat <= voltage_code_active;
            end
            vout_tenth_mv <= {7'd0, voltage_code_sat} * `CCM_VOUT_STEP_TENTH_MV;
        end
    end

    // Good-indicator delays; each restarts whenever its condition drops
    assign good_cond = {bias_good_cond, power_good_cond};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_dly
            reg  [16:0] cyc_reg;
            reg  [4:0]  tick_reg;
            reg         pin_reg;
            wire [4:0]  target = ccm_delay_ticks(gi == 1, gi == 0 ? pg_sel : bias_sel);

            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    cyc_reg  <= 17'd0;
                    tick_reg <= 5'd0;
                    pin_reg  <= 1'b0;
                end else if (!good_cond[gi]) begin
                    cyc_reg  <= 17'd0;
                    tick_reg <= 5'd0;
                    pin_reg  <= 1'b0;
                end else if (tick_reg >= target) begin
                    pin_reg <= 1'b1;
                end else if (cyc_reg == DLY_STEP_CYCLES - 1) begin
                    cyc_reg  <= 17'd0;
                    tick_reg <= tick_reg + 5'd1;
                end else begin
                    cyc_reg <= cyc_reg + 17'd1;
                end
            end
            assign good_pin[gi] = pin_reg;
        end
    endgenerate

    assign power_good_pin = good_pin[0];
    assign bias_good_pin  = good_pin[1];

    // Servo step enable; a period change takes hold at once, as the running count is compared with the new period
    assign servo_period = servo_base << servo_sel;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            servo_cnt_reg <= 16'd0;
            servo_step    <= 1'b0;
        end else if (servo_cnt_reg >= servo_period - 16'd1) begin
            servo_cnt_reg <= 16'd0;
            servo_step    <= 1'b1;
        end else begin
            servo_cnt_reg <= servo_cnt_reg + 16'd1;
            servo_step    <= 1'b0;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            discharge_on <= 1'b0;
        end else begin
            discharge_on <= (servo_down & cfg_servo_prot_reg[`CCM_DISCH_SERVO_BIT])
                          | (~main_converter_on & cfg_servo_prot_reg[`CCM_DISCH_OFF_BIT]);
        end
    end

    assign undervoltage_protect_disable = cfg_servo_prot_reg[`CCM_UVP_DISABLE_BIT];
    assign latch_off_select             = cfg_servo_prot_reg[`CCM_LATCH_OFF_BIT];
    assign aux_5v_enable                = cfg_servo_prot_reg[`CCM_AUX5V_EN_BIT];
    assign aux_regulator_enable         = cfg_servo_prot_reg[`CCM_AUX_LDO_EN_BIT];

endmodule

// [ccm_regs_checker.sv]
// Concurrent checks on the register bank outputs.
// Bound into ccm_regs; sees its ports only.
`timescale 1ns/10ps
module ccm_chk (
    // Clock and reset
    input logic        clk,
    input logic        reset,
    // Register port
    input logic        reg_wr,
    input logic        reg_rd,
    input logic        reg_rvalid,
    input logic [7:0]  reg_addr,
    input logic [7:0]  reg_wdata,
    input logic [7:0]  reg_rdata,
    // Events and voltage code
    input logic [7:0]  event_flags_one,
    input logic [7:0]  event_mask_one,
    input logic [7:0]  event_raise_one,
    input logic        voltage_code_load,
    input logic [2:0]  voltage_code_low,
    input logic [10:0] voltage_code_active,
    input logic [10:0] voltage_code_sat,
    input logic [17:0] vout_tenth_mv,
    // Indicators and control
    input logic        power_good_cond,
    input logic        power_good_pin,
    input logic        undervoltage_protect_disable,
    input logic        latch_off_select,
    input logic        aux_5v_enable,
    input logic        aux_regulator_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_wr_ctl; reg_wr && reg_addr == 8'h09; endsequence
    sequence s_rd_free; reg_rd && (reg_addr < 8'h07 || reg_addr > 8'h0a); endsequence
    property p_raise; 1 |=> (event_raise_one & ~$past(event_flags_one & ~event_mask_one)) == 8'h00; endproperty
    property p_hold; !voltage_code_load |=> $stable(voltage_code_active); endproperty
    property p_low; voltage_code_load |=> voltage_code_active[2:0] == $past(voltage_code_low); endproperty
    property p_sat; 1 |=> voltage_code_sat == ($past(voltage_code_active) >= 11'h780 ? 11'h780
        : $past(voltage_code_active)); endproperty
    property p_vout; 1 |=> vout_tenth_mv == $past(voltage_code_sat) * 18'd125; endproperty
    property p_aux; s_wr_ctl |=> aux_5v_enable == $past(reg_wdata[1])
        && aux_regulator_enable == $past(reg_wdata[0]); endproperty
    property p_prot; s_wr_ctl |=> undervoltage_protect_disable == $past(reg_wdata[3])
        && latch_off_select == $past(reg_wdata[2]); endproperty
    property p_free; s_rd_free |=> reg_rvalid && reg_rdata == 8'h00; endproperty
    property p_pg; !power_good_cond |=> !power_good_pin; endproperty
    a_raise: assert property (p_raise) else $error("raise set for masked flag");
    a_hold: assert property (p_hold) else $error("code moved without load");
    a_low: assert property (p_low) else $error("low code bits not loaded");
    a_sat: assert property (p_sat) else $error("saturated code wrong");
    a_vout: assert property (p_vout) else $error("output step wrong");
    a_aux: assert property (p_aux) else $error("aux enables wrong");
    a_prot: assert property (p_prot) else $error("protection bits wrong");
    a_free: assert property (p_free) else $error("unmapped read not zero");
    a_pg: assert property (p_pg) else $error("power good without condition");
endmodule

bind ccm_regs ccm_chk u_chk (.clk, .reset, .reg_wr, .reg_rd, .reg_rvalid, .reg_addr, .reg_wdata,
    .reg_rdata, .event_flags_one, .event_mask_one, .event_raise_one, .voltage_code_load,
    .voltage_code_low, .voltage_code_active, .voltage_code_sat, .vout_tenth_mv, .power_good_cond,
    .power_good_pin, .undervoltage_protect_disable, .latch_off_select, .aux_5v_enable,
    .aux_regulator_enable);

// [ccm_host.sv]
// Host model driving the internal byte register port.
// Drives on falling edges; read data is taken while it stands, half a cycle after the strobe edge.
`timescale 1ns/10ps
module ccm_host (
    // Clock
    input  logic       clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       reg_rd,
    input  logic [7:0] reg_rdata,
    input  logic       reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Released lines flip so a stale value never passes for a request
    task automatic idle;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        idle();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        // The valid pulse lasts one cycle only, so it must be taken before the next rising edge
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
        reg_rd = 1'b0;
        idle();
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the register bank with host model and checker.
// Short delay and servo counts keep every timing case brief.
`timescale 1ns/10ps
module tb_top;
    localparam int DLY = 4;
    localparam int SB = 2;
    logic clk = 1'b0, reset = 1'b1, reg_wr, reg_rd, reg_rvalid, vload = 1'b0;
    logic pgc = 1'b0, bgc = 1'b0, mon = 1'b1, sdn = 1'b0, er_any, pgp, bgp, step, dis, uvp, lat, a5, ald;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, er1, er2, f1 = 8'h00, f2 = 8'h00, m1 = 8'h00;
    logic [2:0] vlow = 3'd0;
    logic [10:0] act, sat;
    logic [17:0] vout;
    int errors = 0;
    int checks_done = 0;
    initial forever #25 clk = ~clk;
    ccm_regs #(.DLY_STEP_CYCLES(DLY), .SERVO_BASE_CYCLES(SB)) u_dut (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .event_flags_one(f1), .event_flags_two(f2),
        .event_mask_one(m1), .event_raise_one(er1), .event_raise_two(er2), .event_raise_any(er_any),
        .voltage_code_low(vlow), .voltage_code_load(vload), .voltage_code_active(act),
        .voltage_code_sat(sat), .vout_tenth_mv(vout), .power_good_cond(pgc), .bias_good_cond(bgc),
        .power_good_pin(pgp), .bias_good_pin(bgp), .main_converter_on(mon), .servo_down(sdn),
        .servo_step(step), .discharge_on(dis), .undervoltage_protect_disable(uvp),
        .latch_off_select(lat), .aux_5v_enable(a5), .aux_regulator_enable(ald));
    ccm_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out;
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic t_reset;
        logic [7:0] ex [4];
        ex = '{8'h00, 8'h28, 8'hf3, 8'h32};
        for (int i = 0; i < 4; i++) begin
            u_host.rd(8'(8'h07 + i), rv);
            chk("reset value", ex[i], rv);
        end
        chk("active code", 11'h190, act);
        chk("vout", 18'd50000, vout);
    endtask
    task automatic t_regs;
        logic [7:0] ex [6];
        ex = '{8'h00, 8'h7f, 8'hf8, 8'hff, 8'hff, 8'h00};
        for (int i = 0; i < 6; i++) u_host.wr(8'(8'h06 + i), 8'hff);
        for (int i = 0; i < 6; i++) begin
            u_host.rd(8'(8'h06 + i), rv);
            chk("readback", ex[i], rv);
        end
    endtask
    task automatic t_mask;
        u_host.wr(8'h07, 8'h0f);
        u_host.wr(8'h08, 8'h20);
        f1 = 8'hff;
        f2 = 8'hff;
        m1 = 8'h33;
        repeat (2) @(negedge clk);
        chk("raise two global", 8'h00, er2);
        chk("raise one global", 8'h00, er1);
        chk("raise any global", 1'b0, er_any);
        u_host.wr(8'h08, 8'h00);
        @(negedge clk);
        chk("raise two", 8'hf0, er2);
        chk("raise one", 8'hcc, er1);
        chk("raise any", 1'b1, er_any);
    endtask
    task automatic t_ctl;
        logic [7:0] v [2];
        v = '{8'h2a, 8'h15};
        for (int i = 0; i < 2; i++) begin
            u_host.wr(8'h09, v[i]);
            chk("control", v[i][3:0], {uvp, lat, a5, ald});
            sdn = 1'b1;
            mon = 1'b1;
            repeat (2) @(negedge clk);
            chk("discharge servo", v[i][5], dis);
            sdn = 1'b0;
            mon = 1'b0;
            repeat (2) @(negedge clk);
            chk("discharge off", v[i][4], dis);
        end
        mon = 1'b1;
    endtask
    task automatic t_servo;
        int n;
        for (int s = 0; s < 4; s++) begin
            u_host.wr(8'h09, {2'(s), 6'h33});
            // First pulse after a change may be short, so time the later ones
            for (int k = 0; k < 3; k++) begin
                n = 0;
                do begin @(posedge clk); #1 n++; end while (step !== 1'b1 && n < 64);
            end
            chk("servo period", 18'(SB << s), 18'(n));
        end
    endtask
    task automatic t_delay;
        int pt [4];
        int bt [4];
        int np, nb;
        pt = '{0, 1, 4, 16};
        bt = '{4, 5, 6, 12};
        for (int c = 0; c < 4; c++) begin
            u_host.wr(8'h08, {2'(c), 1'b1, 2'(c), 3'b000});
            np = 0;
            nb = 0;
            pgc = 1'b1;
            bgc = 1'b1;
            for (int k = 1; k < 100; k++) begin
                @(posedge clk); #1;
                if (pgp === 1'b1 && np == 0) np = k;
                if (bgp === 1'b1 && nb == 0) nb = k;
            end
            chk("power_good_delay", 18'(pt[c] * DLY + 1), 18'(np));
            chk("bias delay", 18'(bt[c] * DLY + 1), 18'(nb));
            @(negedge clk);
            pgc = 1'b0;
            bgc = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask
    task automatic t_vcode;
        vlow = 3'd7;
        repeat (3) @(negedge clk);
        chk("code before load", 11'h190, act);
        vload = 1'b1;
        @(negedge clk);
        vload = 1'b0;
        repeat (3) @(negedge clk);
        chk("code loaded", 11'h7ff, act);
        chk("code clamped", 11'h780, sat);
        chk("vout clamped", 18'd240000, vout);
        u_host.wr(8'h0a, 8'h1e);
        vlow = 3'd0;
        vload = 1'b1;
        @(negedge clk);
        vload = 1'b0;
        repeat (3) @(negedge clk);
        chk("vout low end", 18'd30000, vout);
    endtask
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_regs();
        t_mask();
        t_ctl();
        t_servo();
        t_delay();
        t_vcode();
        close_out();
    end
    initial begin
        #400000;
        errors++;
        close_out();
    end
endmodule
